//--- verilog/ser_fifo_pkg.sv
// Purpose: shared constants and types for the dual serial fifo pair
// Assumes: both ends and the bench compile this first
// Notes: register offsets are byte addresses on the avalon slave
package ser_fifo_pkg;
    ////////////////////////////////////////////////////////////////////
    // buffer geometry
    localparam int CH_COUNT = 2;
    localparam int DEPTH_SMALL = 64;
    localparam int DEPTH_LARGE = 256;
    localparam int NEAR_LIMIT = 8;

    // reset values of the device flags
    localparam logic READY_RST = 1'b0;
    localparam logic HALF_RST = 1'b0;
    localparam logic NEAR_RST = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // controller register map
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_INT_STAT = 5'h08;
    localparam logic [4:0] OFS_INT_MASK = 5'h0c;
    localparam logic [4:0] OFS_WR0 = 5'h10;
    localparam logic [4:0] OFS_WR1 = 5'h14;
    localparam logic [4:0] OFS_RD0 = 5'h18;
    localparam logic [4:0] OFS_RD1 = 5'h1c;
    localparam int CH_SEL_POS = 2;

    // field positions, two bits each, one per channel, except the one-bit read fields
    localparam int STAT_ROOM_POS = 0;
    localparam int STAT_OR_POS = 2;
    localparam int STAT_HALF_POS = 4;
    localparam int STAT_NL_POS = 6;
    localparam int INT_OR_POS = 0;
    localparam int INT_HALF_POS = 2;
    localparam int RD_BIT_POS = 0;
    localparam int RD_VALID_POS = 1;

    // reset values of controller registers
    localparam logic [1:0] CTRL_RST_VAL = 2'h3;
    localparam logic [3:0] MASK_RST_VAL = 4'h0;
    localparam logic [3:0] INT_RST_VAL = 4'h0;

    // clk cycles after a strobe before synced flags are trusted again
    localparam logic [2:0] SETTLE_CYCLES = 3'h4;

    typedef enum logic [2:0] {
        CTL_IDLE,
        CTL_ARM,
        CTL_HOLD,
        CTL_SETTLE,
        CTL_ACK
    } ctl_state_e;
endpackage : ser_fifo_pkg

//--- verilog/ser_fifo_link_if.sv
// Purpose: pins between the dual fifo device and its controller
// Assumes: index 0 and 1 select the channel
// Notes: all link signals are plain one-way levels
`timescale 1ns/10ps
interface ser_fifo_link_if;
    logic [1:0] write_clock;
    logic [1:0] read_clock;
    logic [1:0] reset_n;
    logic [1:0] write_enable;
    logic [1:0] data_in;
    logic [1:0] read_enable;
    logic [1:0] input_ready;
    logic [1:0] output_ready;
    logic [1:0] data_out;
    logic [1:0] half_full_flag;
    logic [1:0] near_limit_flag;

    // device end
    modport dev (
        input write_clock, read_clock, reset_n, write_enable, data_in, read_enable,
        output input_ready, output_ready, data_out, half_full_flag, near_limit_flag
    );

    // controlling end
    modport ctl (
        output write_clock, read_clock, reset_n, write_enable, data_in, read_enable,
        input input_ready, output_ready, data_out, half_full_flag, near_limit_flag
    );
endinterface : ser_fifo_link_if

//--- verilog/ser_fifo_dev.sv
// Purpose: two independent one-bit-wide fifos with own write and read clocks
// Assumes: clocks run continuously; reset held low over four edges of each
// Notes: pointers cross domains in gray code through flop chains
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] two independent one-bit fifos, 64 or 256
// [R2] store only when write enable and ready
// [R3] read only when read enable and ready
// [R4] clock domains may be fully asynchronous
// [R5] input ready through two write-clock stages
// [R6] output ready through three read-clock stages
// [R7] half flag high at half depth or more
// [R8] presented output bit not counted as stored
// [R9] near flag: eight or fewer stored/free
// [R10] input ready low when full, writes ignored
// [R11] output ready low when empty; high means valid
// [R12] reset held over four edges of each clock
// [R13] reset: half, readies low; near flag high
// [R14] input ready rises second write edge after reset
// [R15] first bit appears third read edge later
// [R16] reset each channel after power-up before use
// [R17] both clocks run continuously, may be independent
// [R18] output bit holds until a read advances it
module ser_fifo_dev #(
    parameter int DEPTH = ser_fifo_pkg::DEPTH_SMALL
) (
    ser_fifo_link_if.dev LINK
);
    // channel 0, fully separate from channel 1
    ser_fifo_lane #(.DEPTH(DEPTH)) u_lane0 ( // [R1]
        .write_clock(LINK.write_clock[0]),
        .read_clock(LINK.read_clock[0]),
        .reset_n(LINK.reset_n[0]),
        .write_enable(LINK.write_enable[0]),
        .data_in(LINK.data_in[0]),
        .read_enable(LINK.read_enable[0]),
        .input_ready(LINK.input_ready[0]),
        .output_ready(LINK.output_ready[0]),
        .data_out(LINK.data_out[0]),
        .half_full_flag(LINK.half_full_flag[0]),
        .near_limit_flag(LINK.near_limit_flag[0])
    );

    // channel 1
    ser_fifo_lane #(.DEPTH(DEPTH)) u_lane1 ( // [R1]
        .write_clock(LINK.write_clock[1]),
        .read_clock(LINK.read_clock[1]),
        .reset_n(LINK.reset_n[1]),
        .write_enable(LINK.write_enable[1]),
        .data_in(LINK.data_in[1]),
        .read_enable(LINK.read_enable[1]),
        .input_ready(LINK.input_ready[1]),
        .output_ready(LINK.output_ready[1]),
        .data_out(LINK.data_out[1]),
        .half_full_flag(LINK.half_full_flag[1]),
        .near_limit_flag(LINK.near_limit_flag[1])
    );
endmodule : ser_fifo_dev

////////////////////////////////////////////////////////////////////////
// one channel: write domain and read domain
module ser_fifo_lane #(
    parameter int DEPTH = ser_fifo_pkg::DEPTH_SMALL
) (
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic reset_n,
    input wire logic write_enable,
    input wire logic data_in,
    input wire logic read_enable,
    output logic input_ready,
    output logic output_ready,
    output logic data_out,
    output logic half_full_flag,
    output logic near_limit_flag
);
    localparam int AW = $clog2(DEPTH);

    typedef logic [AW:0] ptr_t;

    // write side state: storage lives here, it is only written here
    typedef struct packed {
        logic [DEPTH-1:0] mem;
        ptr_t wbin;
        ptr_t wgray;
        ptr_t rsync1;
        ptr_t rsync2;
        logic armed;
        logic ready;
        logic half;
        logic near;
    } wside_s;

    // read side state: presented bit sits outside the memory count
    typedef struct packed {
        ptr_t rbin;
        ptr_t rgray;
        ptr_t wsync1;
        ptr_t wsync2;
        logic bit_out;
        logic ready;
    } rside_s;

    localparam wside_s W_RESET = '{
        mem: '0,
        wbin: '0,
        wgray: '0,
        rsync1: '0,
        rsync2: '0,
        armed: 1'b0,
        ready: ser_fifo_pkg::READY_RST,
        half: ser_fifo_pkg::HALF_RST,
        near: ser_fifo_pkg::NEAR_RST
    };

    localparam rside_s R_RESET = '{
        rbin: '0,
        rgray: '0,
        wsync1: '0,
        wsync2: '0,
        bit_out: 1'b0,
        ready: ser_fifo_pkg::READY_RST
    };

    localparam ptr_t FULL_CNT = ptr_t'(DEPTH);
    localparam ptr_t HALF_CNT = ptr_t'(DEPTH / 2);
    localparam ptr_t NEAR_CNT = ptr_t'(ser_fifo_pkg::NEAR_LIMIT);
    localparam ptr_t NEAR_TOP = ptr_t'(DEPTH - ser_fifo_pkg::NEAR_LIMIT);

    wside_s w_q;
    wside_s w_d;
    rside_s r_q;
    rside_s r_d;
    ptr_t used;
    ptr_t wsync_bin;
    logic take;
    logic pop;
    logic avail;

    function automatic ptr_t to_gray(input ptr_t b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic ptr_t from_gray(input ptr_t g);
        ptr_t b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : from_gray

    ////////////////////////////////////////////////////////////////////
    // write domain next state
    always_comb begin
        w_d = w_q;
        // read pointer enters through two flops before any use
        w_d.rsync1 = r_q.rgray; // [R4]
        w_d.rsync2 = w_q.rsync1; // [R5]
        // ready gates the store, so a full buffer ignores the strobe
        take = write_enable & w_q.ready; // [R2] [R10]
        if (take) begin
            w_d.mem[w_q.wbin[AW-1:0]] = data_in; // [R2]
            w_d.wbin = w_q.wbin + 1'b1;
        end
        w_d.wgray = to_gray(w_d.wbin);
        // count looks ahead by this edge's write so ready drops in time
        used = w_d.wbin - from_gray(w_q.rsync2); // [R8]
        w_d.armed = 1'b1;
        // armed delays the first rise to the second edge after release
        w_d.ready = w_q.armed & (used != FULL_CNT); // [R10] [R14]
        w_d.half = used >= HALF_CNT; // [R7]
        w_d.near = (used <= NEAR_CNT) | (used >= NEAR_TOP); // [R9]
        if (!reset_n) begin
            w_d = W_RESET; // [R13]
        end
    end

    // write domain register
    always_ff @(posedge write_clock) begin
        w_q <= w_d;
    end

    ////////////////////////////////////////////////////////////////////
    // read domain next state
    always_comb begin
        r_d = r_q;
        // two sync flops, the output register is the third stage
        r_d.wsync1 = w_q.wgray; // [R4]
        r_d.wsync2 = r_q.wsync1; // [R6]
        wsync_bin = from_gray(r_q.wsync2);
        avail = wsync_bin != r_q.rbin;
        pop = read_enable & r_q.ready; // [R3]
        if (avail && (!r_q.ready || pop)) begin
            // memory bit is stable: its pointer was published after the store
            r_d.bit_out = w_q.mem[r_q.rbin[AW-1:0]]; // [R11] [R15]
            r_d.rbin = r_q.rbin + 1'b1; // [R8]
            r_d.ready = 1'b1; // [R6] [R15]
        end else if (pop) begin
            // bit_out keeps its last value, only ready drops
            r_d.ready = 1'b0; // [R11] [R18]
        end
        r_d.rgray = to_gray(r_d.rbin);
        if (!reset_n) begin
            r_d = R_RESET; // [R13]
        end
    end

    // read domain register
    always_ff @(posedge read_clock) begin
        r_q <= r_d;
    end

    // every flag comes straight from a flop of its domain
    assign input_ready = w_q.ready; // [R5]
    assign half_full_flag = w_q.half;
    assign near_limit_flag = w_q.near;
    assign output_ready = r_q.ready; // [R6]
    assign data_out = r_q.bit_out; // [R18]
endmodule : ser_fifo_lane

//--- verilog/ser_fifo_ctl.sv
// Purpose: avalon-controlled writer and reader for the dual serial fifo
// Assumes: one master, one request at a time
// Notes: link clocks are CLK divided by two, all four coincident
`timescale 1ns/10ps
module ser_fifo_ctl (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    ser_fifo_link_if.ctl LINK
);
    typedef struct packed {
        ser_fifo_pkg::ctl_state_e st;
        logic div;
        logic [1:0] rst;
        logic [1:0] we;
        logic [1:0] re;
        logic [1:0] din;
        logic [1:0] rst_pin;
        logic [1:0] rm_a;
        logic [1:0] rm_b;
        logic [1:0] or_a;
        logic [1:0] or_b;
        logic [1:0] q_a;
        logic [1:0] q_b;
        logic [1:0] hl_a;
        logic [1:0] hl_b;
        logic [1:0] nl_a;
        logic [1:0] nl_b;
        logic [1:0] or_old;
        logic [1:0] hl_old;
        logic [3:0] ist;
        logic [3:0] imask;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
        logic [2:0] cnt;
        logic ch;
    } ctl_s;

    ctl_s s_q;
    ctl_s s_d;
    logic [3:0] ev;
    logic [3:0] clr;
    logic ch;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        clr = '0;
        ch = AVS_ADDRESS[ser_fifo_pkg::CH_SEL_POS];
        s_d.div = ~s_q.div;
        if (s_q.div) s_d.rst_pin = s_q.rst; // only as link clocks fall [R12]
        // device flags are foreign: two flops before use
        s_d.rm_a = LINK.input_ready;
        s_d.rm_b = s_q.rm_a;
        s_d.or_a = LINK.output_ready;
        s_d.or_b = s_q.or_a;
        s_d.q_a = LINK.data_out;
        s_d.q_b = s_q.q_a;
        s_d.hl_a = LINK.half_full_flag;
        s_d.hl_b = s_q.hl_a;
        s_d.nl_a = LINK.near_limit_flag;
        s_d.nl_b = s_q.nl_a;
        s_d.or_old = s_q.or_b;
        s_d.hl_old = s_q.hl_b;
        case (s_q.st)
            ser_fifo_pkg::CTL_IDLE: begin
                if (AVS_WRITE || AVS_READ) begin
                    s_d.rdata = '0;
                    s_d.waitreq = 1'b0;
                    s_d.st = ser_fifo_pkg::CTL_ACK;
                    s_d.ch = ch;
                end
                if (AVS_WRITE) begin
                    case (AVS_ADDRESS)
                        ser_fifo_pkg::OFS_CTRL: s_d.rst = AVS_WRITEDATA[1:0]; // [R12]
                        ser_fifo_pkg::OFS_INT_MASK: s_d.imask = AVS_WRITEDATA[3:0];
                        ser_fifo_pkg::OFS_WR0, ser_fifo_pkg::OFS_WR1: begin
                            // not ready: dropped here rather than wasted on the pins
                            if (s_q.rm_b[ch] && !s_q.rst[ch]) begin // [R2] [R16]
                                s_d.din[ch] = AVS_WRITEDATA[0];
                                s_d.waitreq = 1'b1;
                                s_d.st = ser_fifo_pkg::CTL_ARM;
                            end
                        end
                        default: ;
                    endcase
                end else if (AVS_READ) begin
                    case (AVS_ADDRESS)
                        ser_fifo_pkg::OFS_CTRL: s_d.rdata[1:0] = s_q.rst;
                        ser_fifo_pkg::OFS_STAT: begin
                            s_d.rdata[ser_fifo_pkg::STAT_ROOM_POS +: 2] = s_q.rm_b;
                            s_d.rdata[ser_fifo_pkg::STAT_OR_POS +: 2] = s_q.or_b;
                            s_d.rdata[ser_fifo_pkg::STAT_HALF_POS +: 2] = s_q.hl_b;
                            s_d.rdata[ser_fifo_pkg::STAT_NL_POS +: 2] = s_q.nl_b;
                        end
                        ser_fifo_pkg::OFS_INT_STAT: begin
                            s_d.rdata[3:0] = s_q.ist;
                            clr = s_q.ist;
                        end
                        ser_fifo_pkg::OFS_INT_MASK: s_d.rdata[3:0] = s_q.imask;
                        ser_fifo_pkg::OFS_RD0, ser_fifo_pkg::OFS_RD1: begin
                            // bit is valid whenever output ready is high
                            if (s_q.or_b[ch] && !s_q.rst[ch]) begin // [R3] [R11]
                                s_d.rdata[ser_fifo_pkg::RD_BIT_POS] = s_q.q_b[ch];
                                s_d.rdata[ser_fifo_pkg::RD_VALID_POS] = 1'b1;
                                s_d.waitreq = 1'b1;
                                s_d.st = ser_fifo_pkg::CTL_ARM;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ser_fifo_pkg::CTL_ARM: begin
                // raise the strobe as the link clock falls, ahead of its rise
                if (s_q.div) begin
                    s_d.we[s_q.ch] = ~s_q.rdata[ser_fifo_pkg::RD_VALID_POS]; // [R2]
                    s_d.re[s_q.ch] = s_q.rdata[ser_fifo_pkg::RD_VALID_POS]; // [R3]
                    s_d.st = ser_fifo_pkg::CTL_HOLD;
                end
            end
            ser_fifo_pkg::CTL_HOLD: begin
                // exactly one link rising edge sees the strobe
                if (s_q.div) begin
                    s_d.we = '0;
                    s_d.re = '0;
                    s_d.cnt = ser_fifo_pkg::SETTLE_CYCLES;
                    s_d.st = ser_fifo_pkg::CTL_SETTLE;
                end
            end
            ser_fifo_pkg::CTL_SETTLE: begin
                // lets the synced flags catch up, so stale ready is never used
                s_d.cnt = s_q.cnt - 3'h1;
                if (s_q.cnt == 3'h1) begin
                    s_d.waitreq = 1'b0;
                    s_d.st = ser_fifo_pkg::CTL_ACK;
                end
            end
            ser_fifo_pkg::CTL_ACK: begin
                s_d.waitreq = 1'b1;
                s_d.st = ser_fifo_pkg::CTL_IDLE;
            end
            default: s_d.st = ser_fifo_pkg::CTL_IDLE;
        endcase
        // sticky events, none in reset; a new event beats the read clear
        ev = {s_q.hl_b & ~s_q.hl_old, s_q.or_b & ~s_q.or_old} & {2{~s_q.rst}};
        s_d.ist = (s_q.ist & ~clr) | ev;
        s_d.irq = |(s_d.ist & s_d.imask);
        if (RST) begin
            s_d = '0;
            s_d.st = ser_fifo_pkg::CTL_IDLE;
            s_d.rst = ser_fifo_pkg::CTRL_RST_VAL; // [R16]
            s_d.rst_pin = ser_fifo_pkg::CTRL_RST_VAL;
            s_d.imask = ser_fifo_pkg::MASK_RST_VAL;
            s_d.ist = ser_fifo_pkg::INT_RST_VAL;
            s_d.waitreq = 1'b1;
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops; link clocks run whenever RST is low
    assign LINK.write_clock = {2{s_q.div}}; // [R17]
    assign LINK.read_clock = {2{s_q.div}}; // [R17]
    assign LINK.reset_n = ~s_q.rst_pin; // [R12]
    assign LINK.write_enable = s_q.we;
    assign LINK.read_enable = s_q.re;
    assign LINK.data_in = s_q.din;
    assign AVS_READDATA = s_q.rdata;
    assign AVS_WAITREQUEST = s_q.waitreq;
    assign IRQ = s_q.irq;
endmodule : ser_fifo_ctl

//--- verif/ser_fifo_asserts.sv
// Purpose: concurrent checks on the link between the fifo device and its controller
// Assumes: link clocks are the coincident ones the controller makes
// Notes: the shadow occupancy counts the bit standing on data_out as well
`timescale 1ns/10ps
module ser_fifo_asserts #(
    parameter int DEPTH = ser_fifo_pkg::DEPTH_SMALL
) (
    input wire logic [1:0] write_clock,
    input wire logic [1:0] read_clock,
    input wire logic [1:0] reset_n,
    input wire logic [1:0] write_enable,
    input wire logic [1:0] data_in,
    input wire logic [1:0] read_enable,
    input wire logic [1:0] input_ready,
    input wire logic [1:0] output_ready,
    input wire logic [1:0] data_out,
    input wire logic [1:0] half_full_flag,
    input wire logic [1:0] near_limit_flag
);
    ////////////////////////////////////////////////////////////////////////////////////////
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [9:0] total_q;
        logic [9:0] total_d;
        logic wr_ok;
        logic rd_ok;
        assign wr_ok = write_enable[c] & input_ready[c];
        assign rd_ok = read_enable[c] & output_ready[c];
        // counted on the write clock only: both clocks share edges on this link
        always_comb begin
            total_d = total_q + 10'(wr_ok) - 10'(rd_ok);
            if (!reset_n[c]) begin
                total_d = '0;
            end
        end
        always_ff @(posedge write_clock[c]) begin
            total_q <= total_d;
        end

        // reset itself is the cause here, so no disable condition
        a_reset_flags: assert property (@(posedge write_clock[c])
            !reset_n[c] && $past(!reset_n[c]) |-> !input_ready[c] && !output_ready[c]
            && !half_full_flag[c] && near_limit_flag[c])
            else $error("flags wrong while channel held in reset");
        a_ready_rise: assert property (@(posedge write_clock[c])
            disable iff (!reset_n[c]) $rose(reset_n[c]) |-> ##1 !input_ready[c] ##1 input_ready[c])
            else $error("input ready not up on second write edge");
        a_full_blocks: assert property (@(posedge write_clock[c])
            disable iff (!reset_n[c]) total_q == 10'(DEPTH + 1) |-> !input_ready[c])
            else $error("input ready high with memory full");
        a_no_underrun: assert property (@(posedge read_clock[c])
            disable iff (!reset_n[c]) output_ready[c] |-> total_q != 10'h0)
            else $error("output ready high with nothing held");
        a_last_pop: assert property (@(posedge read_clock[c])
            disable iff (!reset_n[c]) rd_ok && !wr_ok && total_q == 10'h1 |=> !output_ready[c])
            else $error("output ready stays up after last bit read");
        a_first_bit: assert property (@(posedge read_clock[c])
            disable iff (!reset_n[c]) wr_ok && total_q == 10'h0 |-> ##1 !output_ready[c] [*3]
            ##1 (output_ready[c] && data_out[c] == $past(data_in[c], 4)))
            else $error("first bit not presented on third read edge");
        a_out_hold: assert property (@(posedge read_clock[c])
            disable iff (!reset_n[c]) output_ready[c] && !read_enable[c] |=> $stable(data_out[c]))
            else $error("serial output moved without a read");
        a_half_rise: assert property (@(posedge write_clock[c])
            disable iff (!reset_n[c]) $rose(half_full_flag[c]) |-> total_q == 10'(DEPTH / 2 + 1))
            else $error("half flag rose at wrong fill");
        a_half_fall: assert property (@(posedge write_clock[c])
            disable iff (!reset_n[c]) $fell(half_full_flag[c]) |-> total_q == 10'(DEPTH / 2))
            else $error("half flag fell at wrong fill");
        a_near_fall: assert property (@(posedge write_clock[c])
            disable iff (!reset_n[c]) $fell(near_limit_flag[c])
            |-> total_q == 10'ha || total_q == 10'(DEPTH - 8))
            else $error("near flag fell at wrong fill");

        // main scenarios reached
        c_full: cover property (@(posedge write_clock[c]) total_q == 10'(DEPTH + 1));
        c_half: cover property (@(posedge write_clock[c]) $rose(half_full_flag[c]));
        c_drain: cover property (@(posedge read_clock[c]) rd_ok && total_q == 10'h1);
    end
endmodule : ser_fifo_asserts

//--- verif/tb.sv
// Purpose: drives the controller over avalon and checks the fifo pair end to end
// Assumes: controller makes coincident link clocks from CLK
// Notes: a queue per channel holds what the device should hold, out bit included
`timescale 1ns/10ps
module tb;
    localparam int DEPTH = ser_fifo_pkg::DEPTH_SMALL;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [4:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    int error_cnt = 0;
    int checks_done = 0;
    integer seed = 32'hf768d5bc;
    logic q_bits [2][$];
    logic [31:0] rd;
    logic [31:0] r;

    ser_fifo_link_if link ();
    ser_fifo_dev #(.DEPTH(DEPTH)) ser_fifo_dev_i (.LINK(link.dev));
    ser_fifo_ctl ser_fifo_ctl_i (.CLK(CLK), .RST(RST), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
        .LINK(link.ctl));
    ser_fifo_asserts #(.DEPTH(DEPTH)) ser_fifo_asserts_i (.write_clock(link.write_clock),
        .read_clock(link.read_clock), .reset_n(link.reset_n), .write_enable(link.write_enable),
        .data_in(link.data_in), .read_enable(link.read_enable), .input_ready(link.input_ready),
        .output_ready(link.output_ready), .data_out(link.data_out),
        .half_full_flag(link.half_full_flag), .near_limit_flag(link.near_limit_flag));

    ////////////////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        forever #50 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // one avalon transfer, held until waitrequest is seen low; entered just after an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge CLK);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) check(32'h1, 32'h0, "no bus answer");
        @(posedge CLK);
    endtask : bus

    // status flags expected from n bits held, the presented one included
    function automatic logic [7:0] stat_exp(input int ch, input int n);
        int s;
        logic [7:0] v;
        s = (n > 0) ? n - 1 : 0;
        v = '0;
        v[ser_fifo_pkg::STAT_ROOM_POS + ch] = (n < DEPTH + 1);
        v[ser_fifo_pkg::STAT_OR_POS + ch] = (n != 0);
        v[ser_fifo_pkg::STAT_HALF_POS + ch] = (s >= DEPTH / 2);
        v[ser_fifo_pkg::STAT_NL_POS + ch] = (s <= 8) || (s >= DEPTH - 8);
        return v;
    endfunction : stat_exp

    task automatic check_stat();
        repeat (20) @(posedge CLK);
        bus(1'b0, ser_fifo_pkg::OFS_STAT, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, stat_exp(0, q_bits[0].size())
            | stat_exp(1, q_bits[1].size())}, "status");
    endtask : check_stat

    // a write beyond capacity is dropped by the controller, so the model drops it too
    task automatic put(input int ch, input logic b);
        bus(1'b1, ch ? ser_fifo_pkg::OFS_WR1 : ser_fifo_pkg::OFS_WR0, {31'h0, b});
        if (q_bits[ch].size() < DEPTH + 1) q_bits[ch].push_back(b);
        repeat (2) @(posedge CLK); // let output ready sync
    endtask : put

    task automatic take(input int ch);
        logic [1:0] exp;
        bus(1'b0, ch ? ser_fifo_pkg::OFS_RD1 : ser_fifo_pkg::OFS_RD0, 32'h0);
        exp = 2'b00;
        if (q_bits[ch].size() != 0) exp = {1'b1, q_bits[ch].pop_front()};
        check({30'h0, rd[1:0]}, {30'h0, exp}, "read bit");
    endtask : take

    ////////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        bus(1'b0, ser_fifo_pkg::OFS_CTRL, 32'h0);
        check({30'h0, rd[1:0]}, 32'(ser_fifo_pkg::CTRL_RST_VAL), "ctrl reset");
        bus(1'b0, ser_fifo_pkg::OFS_INT_MASK, 32'h0);
        check({28'h0, rd[3:0]}, 32'(ser_fifo_pkg::MASK_RST_VAL), "mask reset");
        repeat (8) @(posedge CLK);
        bus(1'b0, ser_fifo_pkg::OFS_STAT, 32'h0);
        check({24'h0, rd[7:0]}, 32'hc0, "status in reset");
        bus(1'b1, ser_fifo_pkg::OFS_CTRL, 32'h0);
        check_stat();
        take(0);
        take(1);
        // unmasked output-ready event raises the line, the read clears it
        bus(1'b1, ser_fifo_pkg::OFS_INT_MASK, 32'h1);
        put(0, 1'b1);
        for (int n = 0; n < 50 && irq !== 1'b1; n++) @(posedge CLK);
        check({31'h0, irq}, 32'h1, "irq raised");
        bus(1'b0, ser_fifo_pkg::OFS_INT_STAT, 32'h0);
        check({28'h0, rd[3:0]}, 32'h1, "event bits");
        repeat (2) @(posedge CLK);
        check({31'h0, irq}, 32'h0, "irq cleared");
        // random traffic over both channels
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            if (r[1]) put(int'(r[0]), r[2]);
            else take(int'(r[0]));
        end
        check_stat();
        // fill channel 0 past capacity with the events masked
        bus(1'b1, ser_fifo_pkg::OFS_INT_MASK, 32'h0);
        bus(1'b0, ser_fifo_pkg::OFS_INT_STAT, 32'h0);
        while (q_bits[0].size() < DEPTH + 1) put(0, r[3]);
        r = $random(seed);
        put(0, r[0]);
        check_stat();
        check({31'h0, irq}, 32'h0, "masked irq");
        bus(1'b0, ser_fifo_pkg::OFS_INT_STAT, 32'h0);
        check({30'h0, rd[3:2]}, 32'h1, "half event bits");
        for (int i = 0; i < DEPTH + 2; i++) take(0);
        check_stat();
        tally_and_finish();
    end

    // watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (40000) @(posedge CLK);
        error_cnt++;
        tally_and_finish();
    end
endmodule : tb
